// File: tal_top.sv
// Terminal address latch with AXI4-Lite configuration slave
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module tal_top
  import tal_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [4:0]  term_addr_pins,
  input  wire logic        term_addr_parity_pin,
  input  wire logic        term_addr_latch_ctl,
  output logic [4:0]       term_addr,
  output logic             term_addr_parity,
  output logic             nonbcast_resp_en
);
  logic [15:0]    cfg3_r, cfg3_nxt;
  logic [15:0]    cfg4_r, cfg4_nxt;
  logic [15:0]    cfg5_r, cfg5_nxt;
  logic [15:0]    cfg6_r, cfg6_nxt;
  logic           aw_hold_r, aw_hold_nxt;
  logic [11:0]    aw_addr_r, aw_addr_nxt;
  logic           w_hold_r, w_hold_nxt;
  logic [31:0]    w_data_r, w_data_nxt;
  logic [3:0]     w_strb_r, w_strb_nxt;
  tal_bus_state_t wst_r, wst_nxt;
  logic [1:0]     bresp_r, bresp_nxt;
  logic           rvalid_r, rvalid_nxt;
  logic [31:0]    rdata_r, rdata_nxt;
  logic [1:0]     rresp_r, rresp_nxt;
  logic           do_write;
  logic           host_cap;
  logic [5:0]     host_val;
  logic [5:0]     addr_par;
  logic           src_sw;

  // Apply byte strobes to a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0]  = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a == OFF_CFG3 || a == OFF_CFG4 || a == OFF_CFG5 ||
           a == OFF_CFG6 || a == OFF_STATUS;
  endfunction

  assign s_axi_awready = (wst_r == TAL_IDLE) && !aw_hold_r;
  assign s_axi_wready  = (wst_r == TAL_IDLE) && !w_hold_r;
  assign s_axi_bvalid  = (wst_r == TAL_RESP);
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign do_write      = (wst_r == TAL_IDLE) && aw_hold_r && w_hold_r;
  assign src_sw        = cfg6_r[BIT_SRC_SEL];

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    wst_nxt     = wst_r;
    bresp_nxt   = bresp_r;
    cfg3_nxt    = cfg3_r;
    cfg4_nxt    = cfg4_r;
    cfg5_nxt    = cfg5_r;
    cfg6_nxt    = cfg6_r;
    host_cap    = 1'b0;
    host_val    = {term_addr_pins, term_addr_parity_pin};
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    unique case (wst_r)
      TAL_IDLE: begin
        if (do_write) begin
          aw_hold_nxt = 1'b0;
          w_hold_nxt  = 1'b0;
          wst_nxt     = TAL_RESP;
          bresp_nxt   = mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
          unique case (aw_addr_r)
            OFF_CFG3: cfg3_nxt = merge16(cfg3_r, w_data_r, w_strb_r);
            OFF_CFG4: cfg4_nxt = merge16(cfg4_r, w_data_r, w_strb_r);
            OFF_CFG6: cfg6_nxt = merge16(cfg6_r, w_data_r, w_strb_r);
            OFF_CFG5: begin
              cfg5_nxt = merge16(cfg5_r, w_data_r, w_strb_r);
              // R9: capture needs both enables
              host_cap = cfg3_r[BIT_ENH_EN] && cfg4_r[BIT_LAT5_EN];
              // R8: D5-D1 address, D0 parity
              if (src_sw) begin
                host_val = w_data_r[5:0];
              end
              // R11: pin source ignores data
            end
            default: ;
          endcase
        end
      end
      TAL_RESP: begin
        if (s_axi_bready) begin
          wst_nxt = TAL_IDLE;
        end
      end
      default: wst_nxt = TAL_IDLE;
    endcase
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFF_CFG3:   rdata_nxt = {16'h0000, cfg3_r};
        OFF_CFG4:   rdata_nxt = {16'h0000, cfg4_r};
        OFF_CFG5:   rdata_nxt = {16'h0000, cfg5_r};
        OFF_CFG6:   rdata_nxt = {16'h0000, cfg6_r};
        OFF_STATUS: rdata_nxt = {25'h0000000, nonbcast_resp_en, addr_par};
        default:    rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg3_r    <= CFG_RESET;
      cfg4_r    <= CFG_RESET;
      cfg5_r    <= CFG_RESET;
      cfg6_r    <= CFG_RESET;
      aw_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      wst_r     <= TAL_IDLE;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end else begin
      cfg3_r    <= cfg3_nxt;
      cfg4_r    <= cfg4_nxt;
      cfg5_r    <= cfg5_nxt;
      cfg6_r    <= cfg6_nxt;
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r  <= w_hold_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      wst_r     <= wst_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // R1: R2: pins or bus by select
  tal_latch u_latch (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_addr  (term_addr_pins),
    .pin_par   (term_addr_parity_pin),
    .latch_ctl (term_addr_latch_ctl),
    .host_cap  (host_cap),
    .host_val  (host_val),
    .addr_par  (addr_par)
  );

  assign term_addr        = addr_par[5:1];
  assign term_addr_parity = addr_par[0];
  // R4: odd parity gates response
  assign nonbcast_resp_en = tal_parity_ok(addr_par);
endmodule

// File: tal_pkg.sv
// Constants and register map for the terminal address latch
// Behaviour
// R1: Source select 0 takes address from pins
// R2: Source select 1 takes address from bus
// R3: Supplier makes address plus parity odd
// R4: Respond non-broadcast only on odd parity
// R5: Latch control low passes pins through
// R6: Rising latch control captures pin values
// R7: Latch control high: host-controlled capture only
// R8: Bus D5-D1 is address, D0 parity
// R9: Host sets enhance, latch enable, writes reg5
// R10: Host puts address in low six bits
// R11: Pin source ignores data, captures pins
// R12: Held address stays until next capture
package tal_pkg;
  localparam int          ADDR_W         = 5;
  localparam logic [11:0] OFF_CFG3       = 12'h00C;
  localparam logic [11:0] OFF_CFG4       = 12'h010;
  localparam logic [11:0] OFF_CFG5       = 12'h014;
  localparam logic [11:0] OFF_CFG6       = 12'h018;
  localparam logic [11:0] OFF_STATUS     = 12'h020;
  localparam int          BIT_ENH_EN     = 15;
  localparam int          BIT_LAT5_EN    = 3;
  localparam int          BIT_SRC_SEL    = 5;
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [5:0]  HELD_RESET     = 6'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {
    TAL_IDLE = 2'b00,
    TAL_RESP = 2'b01
  } tal_bus_state_t;

  // Odd parity across address plus parity bit
  function automatic logic tal_parity_ok(input logic [5:0] ap);
    return ^ap;
  endfunction
endpackage

// File: tal_latch.sv
// Address hold register with transparent and captured modes
`timescale 1ns/1ps
module tal_latch
  import tal_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [4:0] pin_addr,
  input  wire logic       pin_par,
  input  wire logic       latch_ctl,
  input  wire logic       host_cap,
  input  wire logic [5:0] host_val,
  output logic      [5:0] addr_par
);
  logic [5:0] held_r;
  logic [5:0] held_nxt;
  logic       ctl_r;
  logic       ctl_nxt;

  always_comb begin
    held_nxt = held_r;
    ctl_nxt  = latch_ctl;
    // R6: capture on rise
    if (latch_ctl && !ctl_r) begin
      held_nxt = {pin_addr, pin_par};
    end else if (host_cap && latch_ctl && ctl_r) begin
      // R7: host capture
      held_nxt = host_val;
    end
    // R12: otherwise hold
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_r <= HELD_RESET;
      ctl_r  <= 1'b0;
    end else begin
      held_r <= held_nxt;
      ctl_r  <= ctl_nxt;
    end
  end

  // R5: transparent while low
  assign addr_par = latch_ctl ? held_r : {pin_addr, pin_par};
endmodule

// File: tal_straps.sv
// Strap model driving the address pins
`timescale 1ns/1ps
module tal_straps (
  input  wire logic [4:0] val,
  input  wire logic       bad,
  output logic      [4:0] term_addr_pins,
  output logic            term_addr_parity_pin
);
  assign term_addr_pins = val;
  assign term_addr_parity_pin = ~^val ^ bad;
endmodule

// File: tal_monitor.sv
// Port checker for the terminal address latch
`timescale 1ns/1ps
module tal_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [4:0] term_addr_pins,
  input wire logic       term_addr_parity_pin,
  input wire logic       term_addr_latch_ctl,
  input wire logic [4:0] term_addr,
  input wire logic       term_addr_parity,
  input wire logic       nonbcast_resp_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_parity_resp: assert property (
    nonbcast_resp_en == ^{term_addr, term_addr_parity}) else $error("resp enable wrong");
  a_pin_pass: assert property (
    !term_addr_latch_ctl |-> {term_addr, term_addr_parity} ==
    {term_addr_pins, term_addr_parity_pin}) else $error("pins not passed");
  a_rise_capture: assert property (
    $rose(term_addr_latch_ctl) ##1 term_addr_latch_ctl |-> {term_addr, term_addr_parity}
    == $past({term_addr_pins, term_addr_parity_pin})) else $error("rise not captured");
  a_held_stable: assert property (
    term_addr_latch_ctl[*3] ##0 !$rose(s_axi_bvalid) |->
    $stable({term_addr, term_addr_parity})) else $error("held address moved");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  a_read_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("no write response");
endmodule
bind tal_top tal_monitor mon (.*);

// File: test_terminal_address_latch.sv
// Self-checking bench for the terminal address latch
`timescale 1ns/1ps
module test_terminal_address_latch
  import tal_pkg::*;
;
  logic aclk = 0, aresetn = 0, term_addr_latch_ctl = 0, bad = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, term_addr_parity_pin;
  logic term_addr_parity, nonbcast_resp_en;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, dv;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0]  term_addr_pins, term_addr, val = 0;
  logic [5:0]  held_exp = 0;
  int failures = 0, total_checks = 0;
  tal_top dut (.*);
  tal_straps straps (.*);
  always #25 aclk = ~aclk;
  function automatic logic [5:0] odd(input logic [4:0] v);
    return {v, ~^v};
  endfunction
  task automatic chk(input string n, input logic [5:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(negedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (!s_axi_rvalid);
    dv = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(83));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      val <= $urandom;
      bad <= i[0];
      @(negedge aclk);
      chk("pass", {term_addr, term_addr_parity}, odd(val) ^ 6'(bad));
      chk("resp", 6'(nonbcast_resp_en), 6'(!bad));
    end
    $display("test pins done");
    @(posedge aclk);
    {bad, val} <= 6'h15;
    @(posedge aclk);
    term_addr_latch_ctl <= 1'h1;
    @(posedge aclk);
    val <= 5'h0A;
    repeat (2) @(negedge aclk);
    chk("rise", {term_addr, term_addr_parity}, odd(5'h15));
    $display("test rise done");
    wr(OFF_CFG3, 32'h8000);
    wr(OFF_CFG4, 32'h8);
    wr(OFF_CFG5, 32'h3F);
    @(negedge aclk);
    chk("host pins", {term_addr, term_addr_parity}, odd(5'h0A));
    $display("test host pins done");
    wr(OFF_CFG6, 32'h20);
    chk("bresp ok", 6'(rsp), 6'(RESP_OKAY));
    for (int i = 0; i < 4; i++) begin
      dv = $urandom;
      val <= $urandom;
      held_exp = odd(dv[4:0]);
      wr(OFF_CFG5, {dv[31:6], odd(dv[4:0])});
      @(negedge aclk);
      chk("host bus", {term_addr, term_addr_parity}, odd(dv[4:0]));
    end
    $display("test host bus done");
    wr(12'hFFC, 32'h1);
    chk("bresp", 6'(rsp), 6'(RESP_SLVERR));
    rd(OFF_STATUS);
    chk("rresp", 6'(rsp), 6'(RESP_OKAY));
    chk("status", dv[5:0], held_exp);
    chk("held out", {term_addr, term_addr_parity}, held_exp);
    chk("status resp", 6'(dv[6]), 6'h01);
    $display("test bus errors done");
    close_out;
  end
  initial begin
    repeat (3000) @(posedge aclk);
    failures++;
    close_out;
  end
endmodule
